// ### hw/iovr_responder.sv
// input over-voltage reaction: decodes the reaction setting and drives
// the output enable through delay, retry and latched-off phases
// assumes fault detection, the time-unit tick and the command decoder
// run on i_clk; only the control pin comes from outside the domain
//
// How it works
// RL1: response 00 ignores the fault, output keeps running.
// RL2: response 01 keeps running for delay count times the unit.
// RL3: after that delay, a still-present fault goes to retry handling.
// RL4: response 10 disables output at once, then follows the retry setting.
// RL5: response 11 disables output until the latched fault is cleared.
// RL6: status clear, clear-all command or reset clears the latched fault.
// RL7: commanding the output off then on also clears the latched fault.
// RL8: retry setting 000 makes no attempt, output stays off until cleared.
// RL9: settings 001 to 101 give one to five attempts, then latch off.
// RL10: attempt starts are spaced by delay count times the unit.
// RL11: setting 110 gives six attempts, then latch off.
// RL12: setting 111 retries forever until off command, reset or shutdown.
// RL13: delay field n selects two to the n units, 1 to 128.
// RL14: attempt fails if fault remains; counter reloads when fault clears.
module iovr_responder
  import iovr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_ce,
  input  wire logic [7:0] i_cmd_code,
  input  wire logic       i_wr_stb,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_clear_faults,
  input  wire logic       i_status_clear,
  input  wire logic       i_ctrl_pin,
  input  wire logic       i_operation_on,
  input  wire logic       i_fault,
  input  wire logic       i_shutdown,
  input  wire logic       i_unit_tick,
  output logic [7:0]      o_rd_data,
  output logic            o_output_enable,
  output logic            o_fault_latched,
  output logic            o_retrying,
  output logic [2:0]      o_retries_left
);
  iovr_cfg_type   cfg;
  iovr_state_type state;
  iovr_state_type next_state;
  logic           ctrl_meta;
  logic           ctrl_sync;
  logic           cmd_q;
  logic           cmd_on;
  logic           on_edge;
  logic           clear_req;
  logic           tmr_start;
  logic           tmr_done;
  logic           cnt_load;
  logic           cnt_dec;
  logic           cnt_last;
  logic           fault_take;
  logic           retry_start;
  logic           sel;

  // control pin is asynchronous to i_clk
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_meta <= 1'b0;
      ctrl_sync <= 1'b0;
    end else if (i_ce) begin
      ctrl_meta <= i_ctrl_pin;
      ctrl_sync <= ctrl_meta;
    end
  end

  assign cmd_on  = ctrl_sync && i_operation_on;
  assign on_edge = cmd_on && !cmd_q;
  assign sel     = (i_cmd_code == IOVR_CFG_CODE);
  // reset itself clears everything through the flop resets
  assign clear_req = i_clear_faults || i_status_clear || on_edge; // RL6 RL7

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cmd_q <= 1'b0;
    end else if (i_ce) begin
      cmd_q <= cmd_on;
    end
  end

  // reaction setting register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg <= iovr_cfg_type'(IOVR_CFG_RESET);
    end else if (i_ce && i_wr_stb && sel) begin
      cfg <= iovr_cfg_type'(i_wr_data);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rd_data <= '0;
    end else if (i_ce) begin
      o_rd_data <= sel ? cfg : 8'h00;
    end
  end

  // retry handling entry: 000 latches, otherwise wait one interval
  always_comb begin
    retry_start = 1'b0;
    if (state == ST_RUN && cmd_on && i_fault && cfg.response == RESP_DISABLE) begin
      retry_start = 1'b1; // RL4
    end
    if (state == ST_DELAY && tmr_done && i_fault) begin
      retry_start = 1'b1; // RL3
    end
  end

  assign fault_take = state == ST_RUN && cmd_on && i_fault && cfg.response != RESP_IGNORE;

  always_comb begin
    next_state = state;
    tmr_start  = 1'b0;
    cnt_dec    = 1'b0;
    case (state)
      ST_RUN: begin
        if (cmd_on && i_fault) begin
          case (cfg.response)
            RESP_IGNORE: next_state = ST_RUN; // RL1
            RESP_RUN_ON: begin
              next_state = ST_DELAY; // RL2
              tmr_start  = 1'b1;
            end
            RESP_LATCH: next_state = ST_LATCHED; // RL5
            default: next_state = ST_RUN;
          endcase
        end
      end
      ST_DELAY: begin
        if (tmr_done && !i_fault) begin
          next_state = ST_RUN;
        end
      end
      ST_OFF_WAIT: begin
        if (tmr_done) begin
          next_state = ST_ATTEMPT;
          tmr_start  = 1'b1; // RL10
        end
      end
      ST_ATTEMPT: begin
        // the attempt ends one cycle after the output comes back
        if (i_fault) begin
          cnt_dec    = 1'b1; // RL14
          next_state = cnt_last ? ST_LATCHED : ST_OFF_WAIT; // RL9 RL11 RL12
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_LATCHED: begin
        if (clear_req) begin
          next_state = ST_RUN; // RL6 RL7
        end
      end
      default: next_state = ST_RUN;
    endcase
    if (retry_start) begin
      if (cfg.retries == RETRY_NONE) begin
        next_state = ST_LATCHED; // RL8
      end else begin
        next_state = ST_OFF_WAIT;
        tmr_start  = 1'b1;
      end
    end
    // another shutdown ends retrying; an off command ends everything
    if (i_shutdown && (state == ST_OFF_WAIT || state == ST_ATTEMPT || state == ST_DELAY)) begin
      next_state = ST_LATCHED; // RL12
    end
    if (!cmd_on) begin
      next_state = ST_RUN; // RL7 RL12
      tmr_start  = 1'b0;
    end
  end

  assign cnt_load = (next_state == ST_RUN); // RL14

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= ST_RUN;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  // output enable is registered from the next state and the on command, so it changes with the state
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_output_enable <= 1'b0;
    end else if (i_ce) begin
      o_output_enable <= cmd_on && (next_state == ST_RUN || next_state == ST_DELAY
                         || next_state == ST_ATTEMPT); // RL1 RL4 RL5
    end
  end

  // status bit: a new fault wins over a clear in the same cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_fault_latched <= 1'b0;
    end else if (i_ce) begin
      o_fault_latched <= fault_take || (o_fault_latched && !clear_req); // RL6 RL7
    end
  end

  assign o_retrying = (state == ST_OFF_WAIT) || (state == ST_ATTEMPT);

  iovr_unit_timer u_timer (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_start (tmr_start),
    .i_tick  (i_unit_tick),
    .i_exp   (cfg.delay),
    .o_done  (tmr_done)
  );

  iovr_retry_count u_count (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_ce        (i_ce),
    .i_load      (cnt_load),
    .i_dec       (cnt_dec),
    .i_retries   (cfg.retries),
    .o_remaining (o_retries_left),
    .o_last      (cnt_last)
  );

  sequence s_fault_in_run(logic [1:0] r);
    i_ce && state == ST_RUN && cmd_on && i_fault && cfg.response == r;
  endsequence

  sequence s_attempt_fails;
    i_ce && state == ST_ATTEMPT && i_fault && cmd_on && !i_shutdown;
  endsequence

  a_ignore_runs: assert property (@(posedge i_clk) disable iff (i_reset) // RL1
    s_fault_in_run(RESP_IGNORE) |=> state == ST_RUN && o_output_enable)
    else $error("ignored fault disturbed the output");

  a_delay_keeps_on: assert property (@(posedge i_clk) disable iff (i_reset) // RL2
    s_fault_in_run(RESP_RUN_ON) |=> state == ST_DELAY && o_output_enable)
    else $error("delay mode did not keep running");

  a_delay_expiry: assert property (@(posedge i_clk) disable iff (i_reset) // RL3
    (i_ce && state == ST_DELAY && tmr_done && i_fault && cmd_on && !i_shutdown)
    |=> !o_output_enable && (state == ST_OFF_WAIT || state == ST_LATCHED))
    else $error("fault after delay not handled");

  a_disable_now: assert property (@(posedge i_clk) disable iff (i_reset) // RL4
    s_fault_in_run(RESP_DISABLE) |=> !o_output_enable && state != ST_RUN)
    else $error("output not disabled at once");

  a_latch_mode: assert property (@(posedge i_clk) disable iff (i_reset) // RL5
    s_fault_in_run(RESP_LATCH) |=> state == ST_LATCHED && !o_output_enable)
    else $error("latch mode did not latch off");

  a_clear_unlatch: assert property (@(posedge i_clk) disable iff (i_reset) // RL6
    (i_ce && state == ST_LATCHED && cmd_on && (i_clear_faults || i_status_clear))
    |=> state == ST_RUN)
    else $error("clear did not release the latch");

  a_cycle_unlatch: assert property (@(posedge i_clk) disable iff (i_reset) // RL7
    (i_ce && !cmd_on) |=> state == ST_RUN && !o_output_enable)
    else $error("off command did not end the fault response");

  a_no_retry: assert property (@(posedge i_clk) disable iff (i_reset) // RL8
    (i_ce && retry_start && cmd_on && cfg.retries == RETRY_NONE) |=> state == ST_LATCHED)
    else $error("retry 000 did not latch off");

  a_exhausted: assert property (@(posedge i_clk) disable iff (i_reset) // RL9 RL11
    (s_attempt_fails and cnt_last) |=> state == ST_LATCHED && !o_output_enable)
    else $error("last failed attempt did not latch off");

  a_endless: assert property (@(posedge i_clk) disable iff (i_reset) // RL12
    (s_attempt_fails and cfg.retries == RETRY_ENDLESS) |=> state == ST_OFF_WAIT)
    else $error("endless retry stopped");

  sequence s_retry_phase;
    i_ce && cmd_on && (state == ST_OFF_WAIT || state == ST_ATTEMPT || state == ST_DELAY);
  endsequence

  a_delay_holds: assert property (@(posedge i_clk) disable iff (i_reset) // RL2
    (i_ce && state == ST_DELAY && !tmr_done && cmd_on && !i_shutdown)
    |=> state == ST_DELAY && o_output_enable)
    else $error("delay ended early");

  a_attempt_restart: assert property (@(posedge i_clk) disable iff (i_reset) // RL10
    (i_ce && state == ST_OFF_WAIT && tmr_done && cmd_on && !i_shutdown)
    |=> state == ST_ATTEMPT && o_output_enable)
    else $error("restart attempt not started");

  a_status_sets: assert property (@(posedge i_clk) disable iff (i_reset) // RL6
    (i_ce && fault_take) |=> o_fault_latched)
    else $error("fault status not set");

  a_success_reload: assert property (@(posedge i_clk) disable iff (i_reset) // RL14
    (i_ce && state == ST_ATTEMPT && !i_fault && cmd_on && !i_shutdown)
    |=> state == ST_RUN && o_retries_left == $past(cfg.retries))
    else $error("good attempt did not reload the count");

  a_shutdown_latch: assert property (@(posedge i_clk) disable iff (i_reset) // RL12
    (s_retry_phase and i_shutdown) |=> state == ST_LATCHED && !o_output_enable)
    else $error("shutdown did not stop retrying");
endmodule

// ### hw/iovr_pkg.sv
// shared constants, the configuration layout and the state set for the
// input over-voltage reaction block; assumes nothing else is imported
package iovr_pkg;
  // command code under which the host reaches the reaction setting
  localparam logic [7:0] IOVR_CFG_CODE  = 8'h56;
  // value after reset; nothing fixes it, so disable-and-no-retry is used
  localparam logic [7:0] IOVR_CFG_RESET = 8'h80;
  localparam logic [1:0] RESP_IGNORE  = 2'h0;
  localparam logic [1:0] RESP_RUN_ON  = 2'h1;
  localparam logic [1:0] RESP_DISABLE = 2'h2;
  localparam logic [1:0] RESP_LATCH   = 2'h3;
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_ENDLESS = 3'h7;
  // widest delay is 128 units, so the span needs eight bits
  localparam int SPAN_W = 8;

  // bits 7:6 response, 5:3 retries, 2:0 delay exponent
  typedef struct packed {
    logic [1:0] response;
    logic [2:0] retries;
    logic [2:0] delay;
  } iovr_cfg_type;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_DELAY,
    ST_OFF_WAIT,
    ST_ATTEMPT,
    ST_LATCHED
  } iovr_state_type;

  function automatic logic [SPAN_W-1:0] iovr_span(input logic [2:0] n);
    return SPAN_W'(1) << n;
  endfunction
endpackage

// ### hw/iovr_unit_timer.sv
// counts 2^n delay units from a start pulse and pulses done at the end
// assumes i_tick is a one-cycle pulse per delay unit on the same clock
module iovr_unit_timer
  import iovr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_ce,
  input  wire logic       i_start,
  input  wire logic       i_tick,
  input  wire logic [2:0] i_exp,
  output logic            o_done
);
  logic [SPAN_W-1:0] remain;
  logic [SPAN_W:0]   seen;
  logic [SPAN_W-1:0] span_q;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      remain <= '0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (i_start) begin
        remain <= iovr_span(i_exp); // RL13
      end else if (i_tick && remain != '0) begin
        remain <= remain - SPAN_W'(1);
        if (remain == SPAN_W'(1)) begin
          o_done <= 1'b1; // RL10
        end
      end
    end
  end

  // helper count for the check below only
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      seen   <= '0;
      span_q <= '0;
    end else if (i_ce) begin
      if (i_start) begin
        seen   <= '0;
        span_q <= iovr_span(i_exp);
      end else if (i_tick) begin
        seen <= seen + (SPAN_W+1)'(1);
      end
    end
  end

  a_span_exact: assert property (@(posedge i_clk) disable iff (i_reset) // RL10 RL13
    o_done |-> seen == {1'b0, span_q})
    else $error("delay ended after the wrong number of units");
endmodule

// ### hw/iovr_retry_count.sv
// holds the restart attempts still allowed; reloaded while healthy
// assumes load and decrement come from the same clock domain
module iovr_retry_count
  import iovr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_ce,
  input  wire logic       i_load,
  input  wire logic       i_dec,
  input  wire logic [2:0] i_retries,
  output logic [2:0]      o_remaining,
  output logic            o_last
);
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_remaining <= '0;
    end else if (i_ce) begin
      if (i_load) begin
        o_remaining <= i_retries; // RL14
      end else if (i_dec && o_remaining != '0 && i_retries != RETRY_ENDLESS) begin
        o_remaining <= o_remaining - 3'h1;
      end
    end
  end

  // endless setting never runs out
  assign o_last = (i_retries != RETRY_ENDLESS) && (o_remaining <= 3'h1); // RL9 RL11 RL12

  a_reload_count: assert property (@(posedge i_clk) disable iff (i_reset) // RL14
    (i_ce && i_load) |=> o_remaining == $past(i_retries))
    else $error("retry count not reloaded");
endmodule

// ### dv/iovr_host_model.sv
// host side model: writes and reads the reaction setting, issues fault clears
// assumes the responder samples every request on the rising edge of i_clk
module iovr_host_model
  import iovr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rd_data,
  output logic [7:0]      o_cmd_code,
  output logic            o_wr_stb,
  output logic [7:0]      o_wr_data,
  output logic            o_clear_faults,
  output logic            o_status_clear
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_cmd_code = 8'h00;
    o_wr_stb = 1'b0;
    o_wr_data = 8'h00;
    o_clear_faults = 1'b0;
    o_status_clear = 1'b0;
  end

  task automatic write_cfg(input logic [7:0] code, input logic [7:0] data);
    @(posedge i_clk);
    o_cmd_code <= code;
    o_wr_stb <= 1'b1;
    o_wr_data <= data;
    @(posedge i_clk);
    o_wr_stb <= 1'b0;
    // released byte flips so a stale value cannot pass for a write
    o_wr_data <= ~data;
  endtask

  task automatic read_cfg(input logic [7:0] code, output logic [7:0] data);
    @(posedge i_clk);
    o_cmd_code <= code;
    repeat (2) @(posedge i_clk);
    #1 data = i_rd_data;
  endtask

  task automatic clear(input logic status_bit);
    @(posedge i_clk);
    if (status_bit) o_status_clear <= 1'b1;
    else o_clear_faults <= 1'b1;
    @(posedge i_clk);
    o_status_clear <= 1'b0;
    o_clear_faults <= 1'b0;
  endtask
endmodule

// ### dv/testbench.sv
// self-checking bench for the input over-voltage responder
// assumes a unit tick every 8 clocks; clock enable held high throughout
module testbench
  import iovr_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       fault = 1'b0;
  logic       ctrl_pin = 1'b1;
  logic       shut = 1'b0;
  logic       op_on = 1'b1;
  logic       tick = 1'b0;
  logic [2:0] tcnt = 3'h0;
  logic [7:0] cmd_code, wr_data, rd_data;
  logic       wr_stb, clr_all, clr_stat, en, latched, retrying;
  logic [2:0] left;
  int         err_total = 0;
  int         total_checks = 0;
  int         cycles = 0;

  initial begin
    forever #20 clk = ~clk;
  end

  // periodic ticks make tick counts map to exact cycle counts
  always @(posedge clk) begin
    tcnt <= tcnt + 3'h1;
    tick <= (tcnt == 3'h7);
  end

  iovr_host_model host (.i_clk(clk), .i_rd_data(rd_data), .o_cmd_code(cmd_code),
    .o_wr_stb(wr_stb), .o_wr_data(wr_data), .o_clear_faults(clr_all),
    .o_status_clear(clr_stat));

  iovr_responder uut (.i_clk(clk), .i_reset(reset), .i_ce(1'b1), .i_cmd_code(cmd_code),
    .i_wr_stb(wr_stb), .i_wr_data(wr_data), .i_clear_faults(clr_all),
    .i_status_clear(clr_stat), .i_ctrl_pin(ctrl_pin), .i_operation_on(op_on),
    .i_fault(fault), .i_shutdown(shut), .i_unit_tick(tick), .o_rd_data(rd_data),
    .o_output_enable(en), .o_fault_latched(latched), .o_retrying(retrying),
    .o_retries_left(left));

  task automatic end_of_test();
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // counts enable rises, ticks seen while enabled, and the last rise spacing
  task automatic watch(input int n, output int rises, output int ton, output int gap);
    int   last;
    logic pe;
    rises = 0;
    ton = 0;
    gap = 0;
    last = 0;
    pe = en;
    for (int c = 1; c <= n; c++) begin
      @(posedge clk);
      if (tick && en) ton++;
      if (en && !pe) begin
        rises++;
        gap = c - last;
        last = c;
      end
      pe = en;
    end
  endtask

  task automatic recover();
    @(posedge clk);
    fault <= 1'b0;
    host.clear(1'b0);
    repeat (4) @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    int         n, t, g;
    logic [7:0] d;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    host.read_cfg(IOVR_CFG_CODE, d);
    chk("cfg_reset", IOVR_CFG_RESET, d);
    host.write_cfg(8'h55, 8'h3c);
    host.read_cfg(IOVR_CFG_CODE, d);
    chk("cfg_foreign_write", IOVR_CFG_RESET, d);
    host.read_cfg(8'h55, d);
    chk("rd_other_code", 8'h00, d);
    host.write_cfg(IOVR_CFG_CODE, 8'h00);
    host.read_cfg(IOVR_CFG_CODE, d);
    chk("cfg_rw", 8'h00, d);
    @(posedge clk);
    fault <= 1'b1;
    watch(40, n, t, g);
    chk("ignore_ticks_on", 8'h05, 8'(t));
    chk("ignore_latched", 8'h00, {7'h0, latched});
    recover();
    for (int k = 0; k < 5; k++) begin
      host.write_cfg(IOVR_CFG_CODE, 8'hc0);
      @(posedge clk);
      fault <= 1'b1;
      watch(40, n, t, g);
      #1 chk("latch_state", 8'h01, {6'h0, en, latched});
      @(posedge clk);
      fault <= 1'b0;
      watch(40, n, t, g);
      chk("latch_hold_ticks", 8'h00, 8'(t));
      if (k < 2) host.clear(k[0]);
      else begin
        @(posedge clk);
        if (k == 2) op_on <= 1'b0;
        else if (k == 3) ctrl_pin <= 1'b0;
        else reset <= 1'b1;
        repeat (3) @(posedge clk);
        op_on <= 1'b1;
        ctrl_pin <= 1'b1;
        reset <= 1'b0;
      end
      repeat (4) @(posedge clk);
      #1 chk("cleared_state", 8'h02, {6'h0, en, latched});
    end
    host.read_cfg(IOVR_CFG_CODE, d);
    chk("cfg_after_reset", IOVR_CFG_RESET, d);
    for (int r = 0; r < 7; r++) begin
      host.write_cfg(IOVR_CFG_CODE, {2'b10, 3'(r), 3'h0});
      @(posedge clk);
      fault <= 1'b1;
      watch(16 * r + 48, n, t, g);
      chk("attempts", 8'(r), 8'(n));
      #1 chk("off_after_attempts", 8'h00, {7'h0, en});
      chk("left_spent", 8'h00, {5'h0, left});
      recover();
      chk("reenabled", 8'h01, {7'h0, en});
      chk("left_reload", 8'(r), {5'h0, left});
    end
    host.write_cfg(IOVR_CFG_CODE, 8'h4a);
    do @(posedge clk); while (tick !== 1'b1);
    fault <= 1'b1;
    watch(36, n, t, g);
    chk("run_on_ticks", 8'h04, 8'(t));
    #1 chk("run_on_expired", 8'h01, {6'h0, en, retrying});
    recover();
    repeat (40) @(posedge clk);
    #1 chk("retry_recovered", 8'h06, {3'h0, left, en, retrying});
    host.write_cfg(IOVR_CFG_CODE, 8'hb9);
    @(posedge clk);
    fault <= 1'b1;
    watch(200, n, t, g);
    chk("attempt_spacing", 8'd16, 8'(g));
    chk("endless_many", 8'h01, {7'h0, n >= 10});
    @(posedge clk);
    shut <= 1'b1;
    @(posedge clk);
    shut <= 1'b0;
    watch(40, n, t, g);
    chk("shutdown_stops", 8'h00, 8'(n));
    #1 chk("shutdown_state", 8'h01, {6'h0, retrying, latched});
    @(posedge clk);
    op_on <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("endless_off", 8'h00, {6'h0, en, retrying});
    @(posedge clk);
    op_on <= 1'b1;
    fault <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk("back_on", 8'h02, {6'h0, en, latched});
    end_of_test();
  end
endmodule
